// ==== rtl/ddr2_fe_pkg.sv ====
package ddr2_fe_pkg;

  // Pin widths for the sixteen-bit configuration
  localparam int DQ_W = 16;
  localparam int DM_W = 2;
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int BANKS = 4;

  // Termination covers the dq, mask and strobe balls of the active width
  localparam int TERM_BALLS = DQ_W + DM_W + DM_W;

  // Internal word store
  localparam int MEM_AW = 4;
  localparam int MEM_DW = 2 * DQ_W;
  localparam int MEM_BE = 4;

  // Command codes {ras_b, cas_b, we_b}
  localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // Extended mode register select, termination field and precharge-all bit positions
  localparam logic [1:0] EMR_BANK = 2'h1;
  localparam int RTT_BIT_LO = 2;
  localparam int RTT_BIT_HI = 6;
  localparam int AUTO_PRE_BIT = 10;

  // Reset values
  localparam logic ODT_ALLOW_RST = 1'b0;
  localparam logic [BANKS-1:0] BANK_OPEN_RST = 4'h0;

  // Power states, Gray coded along entry and exit
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_PD_PRE = 2'b01,
    PWR_PD_ACT = 2'b10
  } pwr_state_e;

endpackage

// ==== rtl/ddr2_frontend.sv ====
`timescale 1ns/10ps
module ddr2_frontend (
  // Core clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Link clock (CK true phase; CK# is its complement)
  input wire logic ck_in,
  // Control and address pins
  input wire logic cke_in,
  input wire logic cs_b_in,
  input wire logic ras_b_in,
  input wire logic cas_b_in,
  input wire logic we_b_in,
  input wire logic [ddr2_fe_pkg::BA_W-1:0] ba_in,
  input wire logic [ddr2_fe_pkg::ADDR_W-1:0] addr_in,
  input wire logic odt_in,
  // Data mask pins, bit 0 low byte
  input wire logic [ddr2_fe_pkg::DM_W-1:0] dm_in,
  // Data bus
  input wire logic [ddr2_fe_pkg::DQ_W-1:0] dq_in,
  output logic [ddr2_fe_pkg::DQ_W-1:0] dq_out,
  output logic [ddr2_fe_pkg::DQ_W-1:0] dq_oe_out,
  // Data strobes, bit 0 low byte
  output logic [ddr2_fe_pkg::DM_W-1:0] dqs_out,
  output logic [ddr2_fe_pkg::DM_W-1:0] dqs_oe_out,
  // Termination and receiver enables at the link
  output logic [ddr2_fe_pkg::TERM_BALLS-1:0] term_en_out,
  output logic cmd_rx_en_out,
  output logic clk_run_out,
  // Core side status
  output logic cmd_valid_out,
  output logic [2:0] cmd_code_out,
  output logic [ddr2_fe_pkg::BA_W-1:0] cmd_bank_out,
  output logic [ddr2_fe_pkg::ADDR_W-1:0] cmd_addr_out,
  output logic [1:0] pwr_state_out,
  output logic self_refresh_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release in both domains

  logic core_rst_s1_reg;
  logic core_rst_b_reg;
  logic link_rst_s1_reg;
  logic link_rst_b_reg;

  // Core reset: asserted at once, released through two flops
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      core_rst_s1_reg <= 1'b0;
      core_rst_b_reg <= 1'b0;
    end
    else
    begin
      core_rst_s1_reg <= 1'b1;
      core_rst_b_reg <= core_rst_s1_reg;
    end
  end

  // Link reset: same scheme on the link clock
  always_ff @(posedge ck_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      link_rst_s1_reg <= 1'b0;
      link_rst_b_reg <= 1'b0;
    end
    else
    begin
      link_rst_s1_reg <= 1'b1;
      link_rst_b_reg <= link_rst_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: pin capture on the rising CK crossing

  function automatic logic is_cmd(input logic [2:0] code, input logic [2:0] want);
    is_cmd = (code == want);
  endfunction

  logic cke_reg;
  logic cs_b_reg;
  logic [2:0] code_reg;
  logic [ddr2_fe_pkg::BA_W-1:0] ba_reg;
  logic [ddr2_fe_pkg::ADDR_W-1:0] addr_reg;
  logic odt_reg;

  // Only the rising CK edge samples address and control
  always_ff @(posedge ck_in or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      cke_reg <= 1'b0;
      cs_b_reg <= 1'b1;
      code_reg <= ddr2_fe_pkg::CMD_NOP;
      ba_reg <= '0;
      addr_reg <= '0;
      odt_reg <= 1'b0;
    end
    else
    begin
      cke_reg <= cke_in;
      cs_b_reg <= cs_b_in;
      code_reg <= {ras_b_in, cas_b_in, we_b_in};
      ba_reg <= ba_in;
      addr_reg <= addr_in;
      odt_reg <= odt_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: power state

  ddr2_fe_pkg::pwr_state_e pwr_reg;
  ddr2_fe_pkg::pwr_state_e pwr_next;
  logic sr_reg;
  logic cke_prev_reg;
  logic [ddr2_fe_pkg::BANKS-1:0] bank_open_reg;

  wire link_active = (pwr_reg == ddr2_fe_pkg::PWR_ACTIVE) && !sr_reg;
  wire cke_fall = cke_prev_reg && !cke_reg;
  wire cke_rise = !cke_prev_reg && cke_reg;
  wire sr_entry = link_active && cke_fall && !cs_b_reg
                  && is_cmd(code_reg, ddr2_fe_pkg::CMD_REFRESH);
  // Commands pass only with clocking on, CS low and receivers alive
  wire cmd_take = link_active && cke_prev_reg && cke_reg && !cs_b_reg;

  // Power-down choice follows open rows
  always_comb
  begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      ddr2_fe_pkg::PWR_ACTIVE:
      begin
        if (cke_fall && !sr_entry && !sr_reg)
        begin
          pwr_next = (|bank_open_reg) ? ddr2_fe_pkg::PWR_PD_ACT
                                      : ddr2_fe_pkg::PWR_PD_PRE;
        end
      end
      ddr2_fe_pkg::PWR_PD_PRE, ddr2_fe_pkg::PWR_PD_ACT:
      begin
        if (cke_rise)
        begin
          pwr_next = ddr2_fe_pkg::PWR_ACTIVE;
        end
      end
      default:
      begin
        pwr_next = ddr2_fe_pkg::PWR_ACTIVE;
      end
    endcase
  end

  // Power-down state and CKE history
  always_ff @(posedge ck_in or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      pwr_reg <= ddr2_fe_pkg::PWR_ACTIVE;
      cke_prev_reg <= 1'b0;
    end
    else
    begin
      pwr_reg <= pwr_next;
      cke_prev_reg <= sr_reg ? 1'b0 : cke_reg;
    end
  end

  // Self refresh: entered on an edge, left as soon as CKE rises, clock or not
  always_ff @(posedge ck_in or negedge link_rst_b_reg or posedge cke_in)
  begin
    if (!link_rst_b_reg)
    begin
      sr_reg <= 1'b0;
    end
    else if (cke_in)
    begin
      sr_reg <= 1'b0;
    end
    else if (sr_entry)
    begin
      sr_reg <= 1'b1;
    end
  end

  // Open-row tracking
  always_ff @(posedge ck_in or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      bank_open_reg <= ddr2_fe_pkg::BANK_OPEN_RST;
    end
    else if (cmd_take && is_cmd(code_reg, ddr2_fe_pkg::CMD_ACTIVATE))
    begin
      bank_open_reg[ba_reg] <= 1'b1;
    end
    else if (cmd_take && is_cmd(code_reg, ddr2_fe_pkg::CMD_PRECHARGE))
    begin
      if (addr_reg[ddr2_fe_pkg::AUTO_PRE_BIT])
      begin
        bank_open_reg <= ddr2_fe_pkg::BANK_OPEN_RST;
      end
      else
      begin
        bank_open_reg[ba_reg] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: termination

  logic odt_allow_reg;
  logic [ddr2_fe_pkg::TERM_BALLS-1:0] term_reg;
  logic rx_en_reg;
  logic clk_run_reg;

  wire emr_load = cmd_take && is_cmd(code_reg, ddr2_fe_pkg::CMD_LOAD_MODE)
                  && (ba_reg == ddr2_fe_pkg::EMR_BANK);
  wire rtt_on = addr_reg[ddr2_fe_pkg::RTT_BIT_HI] | addr_reg[ddr2_fe_pkg::RTT_BIT_LO];
  // ODT kept alive through power-down, dropped in self refresh
  wire term_now = odt_reg && odt_allow_reg && !sr_reg;

  // Termination switch and receiver status
  always_ff @(posedge ck_in or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      odt_allow_reg <= ddr2_fe_pkg::ODT_ALLOW_RST;
      term_reg <= '0;
      rx_en_reg <= 1'b0;
      clk_run_reg <= 1'b0;
    end
    else
    begin
      if (emr_load)
      begin
        odt_allow_reg <= rtt_on;
      end
      term_reg <= {ddr2_fe_pkg::TERM_BALLS{term_now}};
      rx_en_reg <= link_active;
      clk_run_reg <= cke_reg && !sr_reg;
    end
  end

  assign term_en_out = term_reg;
  assign cmd_rx_en_out = rx_en_reg;
  assign clk_run_out = clk_run_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: write capture (rising beat, then falling beat)

  logic wr_arm_reg;
  logic wr_beat_reg;
  logic [ddr2_fe_pkg::MEM_AW-1:0] wr_addr_reg;
  logic [ddr2_fe_pkg::DQ_W-1:0] beat0_reg;
  logic [ddr2_fe_pkg::DM_W-1:0] mask0_reg;
  logic [ddr2_fe_pkg::DQ_W-1:0] beat1_reg;
  logic [ddr2_fe_pkg::DM_W-1:0] mask1_reg;

  wire wr_cmd = cmd_take && is_cmd(code_reg, ddr2_fe_pkg::CMD_WRITE);
  // Lane enables: each mask gates its own byte of each beat
  wire [ddr2_fe_pkg::MEM_BE-1:0] wr_be = ~{mask1_reg, mask0_reg};

  // Rising-edge beat and write sequencing
  always_ff @(posedge ck_in or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      wr_arm_reg <= 1'b0;
      wr_beat_reg <= 1'b0;
      wr_addr_reg <= '0;
      beat0_reg <= '0;
      mask0_reg <= '0;
    end
    else
    begin
      wr_arm_reg <= wr_cmd;
      wr_beat_reg <= wr_arm_reg && link_active;
      if (wr_cmd)
      begin
        wr_addr_reg <= addr_reg[ddr2_fe_pkg::MEM_AW-1:0];
      end
      if (wr_arm_reg)
      begin
        beat0_reg <= dq_in;
        mask0_reg <= dm_in;
      end
    end
  end

  // Falling-edge beat
  always_ff @(negedge ck_in or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      beat1_reg <= '0;
      mask1_reg <= '0;
    end
    else if (wr_beat_reg)
    begin
      beat1_reg <= dq_in;
      mask1_reg <= dm_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: store and read path

  logic [ddr2_fe_pkg::MEM_DW-1:0] rd_word;
  logic rd_arm_reg;
  logic rd_drive_reg;
  logic [ddr2_fe_pkg::DQ_W-1:0] rise_data_reg;
  logic [ddr2_fe_pkg::DQ_W-1:0] fall_data_reg;

  wire rd_cmd = cmd_take && is_cmd(code_reg, ddr2_fe_pkg::CMD_READ);

  lane_store u_store (
    .clk_in(ck_in),
    .rst_b_in(link_rst_b_reg),
    .wr_en_in(wr_beat_reg),
    .wr_addr_in(wr_addr_reg),
    .wr_data_in({beat1_reg, beat0_reg}),
    .wr_be_in(wr_be),
    .rd_en_in(rd_cmd),
    .rd_addr_in(addr_reg[ddr2_fe_pkg::MEM_AW-1:0]),
    .rd_data_out(rd_word)
  );

  // First read beat and drive launched from the rising CK crossing
  always_ff @(posedge ck_in or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      rd_arm_reg <= 1'b0;
      rd_drive_reg <= 1'b0;
      rise_data_reg <= '0;
    end
    else
    begin
      rd_arm_reg <= rd_cmd;
      rd_drive_reg <= rd_arm_reg && link_active;
      rise_data_reg <= rd_word[ddr2_fe_pkg::DQ_W-1:0];
    end
  end

  // Second beat launched from the falling crossing
  always_ff @(negedge ck_in or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      fall_data_reg <= '0;
    end
    else
    begin
      fall_data_reg <= rd_word[ddr2_fe_pkg::MEM_DW-1:ddr2_fe_pkg::DQ_W];
    end
  end

  // Double-rate output select and edge-aligned strobe follow CK itself
  assign dq_out = ck_in ? rise_data_reg : fall_data_reg;
  assign dq_oe_out = {ddr2_fe_pkg::DQ_W{rd_drive_reg}};
  assign dqs_out = {ddr2_fe_pkg::DM_W{ck_in && rd_drive_reg}};
  assign dqs_oe_out = {ddr2_fe_pkg::DM_W{rd_drive_reg}};

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: command word for the core, handed over by toggle

  logic cmd_tgl_reg;
  logic [2:0] hold_code_reg;
  logic [ddr2_fe_pkg::BA_W-1:0] hold_ba_reg;
  logic [ddr2_fe_pkg::ADDR_W-1:0] hold_addr_reg;

  // Word held until the next accepted command other than NOP
  always_ff @(posedge ck_in or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      cmd_tgl_reg <= 1'b0;
      hold_code_reg <= ddr2_fe_pkg::CMD_NOP;
      hold_ba_reg <= '0;
      hold_addr_reg <= '0;
    end
    else if (cmd_take && !is_cmd(code_reg, ddr2_fe_pkg::CMD_NOP))
    begin
      cmd_tgl_reg <= !cmd_tgl_reg;
      hold_code_reg <= code_reg;
      hold_ba_reg <= ba_reg;
      hold_addr_reg <= addr_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: synchronisers and status outputs

  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic [1:0] pwr_s1_reg;
  logic [1:0] pwr_s2_reg;
  logic sr_s1_reg;
  logic sr_s2_reg;
  logic cmd_valid_reg;
  logic [2:0] cmd_code_reg;
  logic [ddr2_fe_pkg::BA_W-1:0] cmd_bank_reg;
  logic [ddr2_fe_pkg::ADDR_W-1:0] cmd_addr_reg;

  wire tgl_edge = tgl_s2_reg ^ tgl_s3_reg;

  // Two-flop crossings; the state code is Gray so one bit moves at a time
  always_ff @(posedge mclk_in or negedge core_rst_b_reg)
  begin
    if (!core_rst_b_reg)
    begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      pwr_s1_reg <= 2'h0;
      pwr_s2_reg <= 2'h0;
      sr_s1_reg <= 1'b0;
      sr_s2_reg <= 1'b0;
    end
    else
    begin
      tgl_s1_reg <= cmd_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      pwr_s1_reg <= pwr_reg;
      pwr_s2_reg <= pwr_s1_reg;
      sr_s1_reg <= sr_reg;
      sr_s2_reg <= sr_s1_reg;
    end
  end

  // Command report: one-cycle pulse, word held until the next
  always_ff @(posedge mclk_in or negedge core_rst_b_reg)
  begin
    if (!core_rst_b_reg)
    begin
      cmd_valid_reg <= 1'b0;
      cmd_code_reg <= ddr2_fe_pkg::CMD_NOP;
      cmd_bank_reg <= '0;
      cmd_addr_reg <= '0;
    end
    else
    begin
      cmd_valid_reg <= tgl_edge;
      if (tgl_edge)
      begin
        cmd_code_reg <= hold_code_reg;
        cmd_bank_reg <= hold_ba_reg;
        cmd_addr_reg <= hold_addr_reg;
      end
    end
  end

  assign cmd_valid_out = cmd_valid_reg;
  assign cmd_code_out = cmd_code_reg;
  assign cmd_bank_out = cmd_bank_reg;
  assign cmd_addr_out = cmd_addr_reg;
  assign pwr_state_out = pwr_s2_reg;
  assign self_refresh_out = sr_s2_reg;

endmodule

// ==== rtl/lane_store.sv ====
`timescale 1ns/10ps
module lane_store (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [ddr2_fe_pkg::MEM_AW-1:0] wr_addr_in,
  input wire logic [ddr2_fe_pkg::MEM_DW-1:0] wr_data_in,
  input wire logic [ddr2_fe_pkg::MEM_BE-1:0] wr_be_in,
  // Read port
  input wire logic rd_en_in,
  input wire logic [ddr2_fe_pkg::MEM_AW-1:0] rd_addr_in,
  output logic [ddr2_fe_pkg::MEM_DW-1:0] rd_data_out
);

  logic [ddr2_fe_pkg::MEM_DW-1:0] mem [2**ddr2_fe_pkg::MEM_AW];
  logic [ddr2_fe_pkg::MEM_DW-1:0] rd_data_reg;

  // Byte-lane write; a cleared enable leaves that byte untouched
  always_ff @(posedge clk_in)
  begin
    for (int i = 0; i < ddr2_fe_pkg::MEM_BE; i++)
    begin
      if (wr_en_in && wr_be_in[i])
      begin
        mem[wr_addr_in][8*i +: 8] <= wr_data_in[8*i +: 8];
      end
    end
  end

  // Registered read data
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_data_reg <= '0;
    end
    else if (rd_en_in)
    begin
      rd_data_reg <= mem[rd_addr_in];
    end
  end

  assign rd_data_out = rd_data_reg;

endmodule

// ==== sim/ddr2_control_input_frontend_tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
    end \
  end
module ddr2_control_input_frontend_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ck = 1'b0;
  logic ck_go = 1'b1;
  int miscompares = 0;
  int samples_checked = 0;
  int pulses = 0;
  logic cke, cs_b, odt, rx_en, run, valid, sr;
  logic [2:0] cmd_b, code;
  logic [1:0] ba, dm, dqs, dqs_oe, bank, pwr;
  logic [12:0] addr, caddr;
  logic [15:0] dq_w, dq_r, dq_oe;
  logic [19:0] term;
  ////////////////////////////////////////////////////////////////////////////////
  // Core clock, and a link clock that can be held still
  always #10 mclk = ~mclk;
  initial
  begin
    #3;
    forever
    begin
      ck = ck_go ? ~ck : ck;
      #40;
    end
  end
  // Device, controller model and pulse counter
  ddr2_frontend dut (.mclk_in(mclk), .rst_b_in(rst_b), .ck_in(ck), .cke_in(cke),
    .cs_b_in(cs_b), .ras_b_in(cmd_b[2]), .cas_b_in(cmd_b[1]), .we_b_in(cmd_b[0]),
    .ba_in(ba), .addr_in(addr), .odt_in(odt), .dm_in(dm), .dq_in(dq_w), .dq_out(dq_r),
    .dq_oe_out(dq_oe), .dqs_out(dqs), .dqs_oe_out(dqs_oe), .term_en_out(term),
    .cmd_rx_en_out(rx_en), .clk_run_out(run), .cmd_valid_out(valid),
    .cmd_code_out(code), .cmd_bank_out(bank), .cmd_addr_out(caddr),
    .pwr_state_out(pwr), .self_refresh_out(sr));
  ddr2_ctl_model ctl (.ck_in(ck), .cke_out(cke), .cs_b_out(cs_b), .cmd_b_out(cmd_b),
    .ba_out(ba), .addr_out(addr), .odt_out(odt), .dm_out(dm), .dq_out(dq_w));
  always @(posedge mclk)
  begin
    if (valid === 1'b1)
      pulses++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Settle a few link cycles past a rise
  task automatic ck_wait(input int n);
    repeat (n) @(posedge ck);
    #10;
  endtask
  // Activate is reported; a deselected read is not
  task automatic t_cmd();
    int p;
    p = pulses;
    ctl.cmd(1'b1, 1'b0, ddr2_fe_pkg::CMD_ACTIVATE, 2'h2, 13'h0155);
    ck_wait(3);
    `CHK("act_pulse", p + 1, pulses)
    `CHK("act_code", ddr2_fe_pkg::CMD_ACTIVATE, code)
    `CHK("act_bank", 2'h2, bank)
    `CHK("act_row", 13'h0155, caddr)
    p = pulses;
    ctl.cmd(1'b1, 1'b1, ddr2_fe_pkg::CMD_READ, 2'h2, 13'h0003);
    ck_wait(3);
    `CHK("cs_masked", p, pulses)
    `CHK("cs_no_drive", 16'h0000, dq_oe)
  endtask
  // Termination follows odt only while a mode load allows it
  task automatic t_term();
    ctl.lvl(1'b1, 1'b1);
    ck_wait(3);
    `CHK("term_reset", 20'h00000, term)
    ctl.cmd(1'b1, 1'b0, ddr2_fe_pkg::CMD_LOAD_MODE, ddr2_fe_pkg::EMR_BANK, 13'h0004);
    ck_wait(3);
    `CHK("term_on", 20'hfffff, term)
    ctl.lvl(1'b1, 1'b0);
    ck_wait(3);
    `CHK("term_off", 20'h00000, term)
    ctl.cmd(1'b1, 1'b0, ddr2_fe_pkg::CMD_LOAD_MODE, ddr2_fe_pkg::EMR_BANK, 13'h0000);
    ctl.lvl(1'b1, 1'b1);
    ck_wait(3);
    `CHK("odt_ignored", 20'h00000, term)
    ctl.cmd(1'b1, 1'b0, ddr2_fe_pkg::CMD_LOAD_MODE, ddr2_fe_pkg::EMR_BANK, 13'h0040);
    ck_wait(3);
    `CHK("term_on_hi", 20'hfffff, term)
    ctl.lvl(1'b1, 1'b0);
  endtask
  // Full write, masked write on both beats, then read back
  task automatic t_data();
    ctl.cmd(1'b1, 1'b0, ddr2_fe_pkg::CMD_WRITE, 2'h2, 13'h0003);
    ctl.beats(32'h89ab_cdef, 4'h0);
    ctl.cmd(1'b1, 1'b0, ddr2_fe_pkg::CMD_WRITE, 2'h2, 13'h0003);
    ctl.beats(32'h1234_5678, 4'h6);
    ctl.cmd(1'b1, 1'b0, ddr2_fe_pkg::CMD_READ, 2'h2, 13'h0003);
    ck_wait(2);
    `CHK("rd_oe", 16'hffff, dq_oe)
    `CHK("rd_strobe_oe", 2'h3, dqs_oe)
    `CHK("rd_beat0", 16'hcd78, dq_r)
    `CHK("rd_strobe_hi", 2'h3, dqs)
    @(negedge ck);
    #10;
    `CHK("rd_beat1", 16'h12ab, dq_r)
    `CHK("rd_strobe_lo", 2'h0, dqs)
    ck_wait(1);
    `CHK("rd_release", 16'h0000, dq_oe)
  endtask
  // Active and precharge power-down, refused command, exit
  task automatic t_pd();
    int p;
    ctl.lvl(1'b0, 1'b0);
    ck_wait(4);
    `CHK("pd_act", 2'h2, pwr)
    `CHK("pd_rx_off", 1'b0, rx_en)
    `CHK("pd_run_off", 1'b0, run)
    p = pulses;
    ctl.cmd(1'b0, 1'b0, ddr2_fe_pkg::CMD_ACTIVATE, 2'h1, 13'h0001);
    ck_wait(3);
    `CHK("pd_refused", p, pulses)
    ctl.lvl(1'b1, 1'b0);
    ck_wait(4);
    `CHK("pd_exit", 2'h0, pwr)
    `CHK("run_on", 1'b1, run)
    ctl.cmd(1'b1, 1'b0, ddr2_fe_pkg::CMD_PRECHARGE, 2'h0, 13'h0400);
    ctl.lvl(1'b0, 1'b0);
    ck_wait(4);
    `CHK("pd_pre", 2'h1, pwr)
    ctl.lvl(1'b1, 1'b0);
    ck_wait(4);
  endtask
  // Self refresh keeps termination off; exit with the clock stopped
  task automatic t_sr();
    ctl.lvl(1'b1, 1'b1);
    ck_wait(3);
    ctl.cmd(1'b0, 1'b0, ddr2_fe_pkg::CMD_REFRESH, 2'h0, 13'h0000);
    ck_wait(4);
    `CHK("sr_in", 1'b1, sr)
    `CHK("sr_run_off", 1'b0, run)
    `CHK("sr_term_off", 20'h00000, term)
    ck_go = 1'b0;
    #100;
    ctl.cke_now(1'b1);
    #100;
    `CHK("sr_exit", 1'b0, sr)
    ck_go = 1'b1;
    ctl.lvl(1'b1, 1'b0);
    ck_wait(4);
    `CHK("sr_rx_on", 1'b1, rx_en)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #200000;
    miscompares++;
    final_report();
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    #2;
    rst_b = 1'b1;
    ctl.lvl(1'b1, 1'b0);
    ck_wait(3);
    t_cmd();
    t_term();
    t_data();
    t_pd();
    t_sr();
    final_report();
  end
endmodule

// ==== sim/ddr2_ctl_model.sv ====
`timescale 1ns/10ps
module ddr2_ctl_model (
  // Link clock
  input wire logic ck_in,
  // Pins towards the device
  output logic cke_out,
  output logic cs_b_out,
  output logic [2:0] cmd_b_out,
  output logic [1:0] ba_out,
  output logic [12:0] addr_out,
  output logic odt_out,
  output logic [1:0] dm_out,
  output logic [15:0] dq_out
);
  // Idle pins at time zero
  initial
  begin
    cke_out = 1'b0;
    cs_b_out = 1'b1;
    cmd_b_out = 3'h7;
    ba_out = 2'h0;
    addr_out = 13'h0000;
    odt_out = 1'b0;
    dm_out = 2'h0;
    dq_out = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Level pins change just after a rise
  task automatic lvl(input logic cke, input logic odt);
    @(posedge ck_in);
    #2;
    cke_out = cke;
    odt_out = odt;
  endtask
  // Self refresh exit needs no clock
  task automatic cke_now(input logic cke);
    cke_out = cke;
  endtask
  // One command; all strobes move together and are then deselected
  task automatic cmd(input logic cke, input logic cs_b, input logic [2:0] c,
    input logic [1:0] b, input logic [12:0] a);
    @(posedge ck_in);
    #2;
    cke_out = cke;
    cs_b_out = cs_b;
    cmd_b_out = c;
    ba_out = b;
    addr_out = a;
    @(posedge ck_in);
    #2;
    cs_b_out = 1'b1;
    cmd_b_out = 3'h7;
    addr_out = ~addr_out;
  endtask
  // Two write beats with their masks, then the bus shows a stale inverse
  task automatic beats(input logic [31:0] w, input logic [3:0] m);
    @(posedge ck_in);
    #2;
    dq_out = w[15:0];
    dm_out = m[1:0];
    @(posedge ck_in);
    #2;
    dq_out = w[31:16];
    dm_out = m[3:2];
    @(posedge ck_in);
    #2;
    dq_out = ~dq_out;
    dm_out = ~dm_out;
  endtask
endmodule

// ==== sim/ddr2_frontend_asserts.sv ====
`timescale 1ns/10ps
module ddr2_frontend_asserts (
  // Clocks and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic ck_in,
  // Watched pins
  input wire logic cke_in,
  input wire logic [ddr2_fe_pkg::DQ_W-1:0] dq_oe_out,
  input wire logic [ddr2_fe_pkg::DM_W-1:0] dqs_out,
  input wire logic [ddr2_fe_pkg::DM_W-1:0] dqs_oe_out,
  input wire logic [ddr2_fe_pkg::TERM_BALLS-1:0] term_en_out,
  input wire logic cmd_rx_en_out,
  input wire logic clk_run_out,
  input wire logic cmd_valid_out,
  input wire logic [2:0] cmd_code_out,
  input wire logic [ddr2_fe_pkg::BA_W-1:0] cmd_bank_out,
  input wire logic [ddr2_fe_pkg::ADDR_W-1:0] cmd_addr_out,
  input wire logic [1:0] pwr_state_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // Core side reporting
  valid_pulse_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    cmd_valid_out |=> !cmd_valid_out) else $error("command pulse too long");
  valid_code_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    cmd_valid_out |-> cmd_code_out != ddr2_fe_pkg::CMD_NOP) else $error("nop reported");
  code_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !cmd_valid_out |-> $stable({cmd_code_out, cmd_bank_out, cmd_addr_out}))
    else $error("command fields moved without pulse");
  pwr_code_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    pwr_state_out != 2'h3) else $error("illegal power state");
  ////////////////////////////////////////////////////////////////////////////////
  // Link pins
  term_equal_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    term_en_out == '0 || term_en_out == '1) else $error("termination bits differ");
  oe_match_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    dq_oe_out == {ddr2_fe_pkg::DQ_W{dqs_oe_out[0]}} && dqs_oe_out[1] == dqs_oe_out[0])
    else $error("data and strobe enables differ");
  strobe_ck_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    dqs_oe_out[0] |-> dqs_out == {2{ck_in}}) else $error("read strobe not following ck");
  oe_one_a: assert property (@(posedge ck_in) disable iff (!rst_b_in)
    $rose(dqs_oe_out[0]) |=> !dqs_oe_out[0]) else $error("read drive not one cycle");
  rx_off_a: assert property (@(posedge ck_in) disable iff (!rst_b_in)
    cke_in ##1 !cke_in [*3] |=> !cmd_rx_en_out) else $error("receivers alive in power-down");
  run_off_a: assert property (@(posedge ck_in) disable iff (!rst_b_in)
    cke_in ##1 !cke_in [*3] |=> !clk_run_out) else $error("clocking on with cke low");
  // Main scenarios
  wr_c: cover property (@(posedge mclk_in) cmd_valid_out && cmd_code_out == 3'h4);
  rd_c: cover property (@(posedge mclk_in) cmd_valid_out && cmd_code_out == 3'h5);
  pda_c: cover property (@(posedge mclk_in) pwr_state_out == 2'h2);
  pdp_c: cover property (@(posedge mclk_in) pwr_state_out == 2'h1);
endmodule

bind ddr2_frontend ddr2_frontend_asserts chk (.mclk_in, .rst_b_in, .ck_in, .cke_in,
  .dq_oe_out, .dqs_out, .dqs_oe_out, .term_en_out, .cmd_rx_en_out, .clk_run_out,
  .cmd_valid_out, .cmd_code_out, .cmd_bank_out, .cmd_addr_out, .pwr_state_out);
